// >>> atthp_map.svh
`ifndef ATTHP_MAP_SVH
`define ATTHP_MAP_SVH

// Register select line values.
`define ATTHP_RS_DATA 1'b0
`define ATTHP_RS_CONTROL 1'b1

// First control register bit positions.
`define ATTHP_CRA_TONE 0
`define ATTHP_CRA_MODE 1
`define ATTHP_CRA_IRQ 2
`define ATTHP_CRA_STEER 3

// Second control register bit positions.
`define ATTHP_CRB_BURST_OFF 0
`define ATTHP_CRB_RX_OFF 1
`define ATTHP_CRB_SINGLE 2
`define ATTHP_CRB_COLUMN 3

// Status register bit positions.
`define ATTHP_ST_IRQ 0
`define ATTHP_ST_TX_EMPTY 1
`define ATTHP_ST_RX_FULL 2
`define ATTHP_ST_DELAYED 3

// Reset values.
`define ATTHP_CRA_RESET 4'h0
`define ATTHP_CRB_RESET 4'h0
`define ATTHP_HOST_IDLE 8'h80
`define ATTHP_CTRL_IDLE 7'h00

// Stages between a latched host write and the transceiver controls.
`define ATTHP_CTRL_STAGES 2

`endif

// >>> atthp_pkg.sv
package atthp_pkg;

  // Host pins as sampled on the clock.
  typedef struct packed {
    logic csN;
    logic strobe;
    logic direction;
    logic regSelect;
    logic [3:0] data;
  } atthp_host_s;

  // Settings handed to the transmitter and receiver.
  typedef struct packed {
    logic toneOutputEnable;
    logic progressModeSelect;
    logic interruptEnable;
    logic burstEnable;
    logic receiverDisable;
    logic singleTone;
    logic columnTone;
  } atthp_ctrl_s;

  // Events and levels from the transmitter and receiver.
  typedef struct packed {
    logic digitValid;
    logic toneAbsent;
    logic txReady;
    logic cpSquare;
    logic [3:0] digitCode;
  } atthp_xcvr_s;

  // Access state, which also holds the detected bus style.
  typedef enum logic [1:0] {
    ATTHP_IDLE = 2'b00,
    ATTHP_STROBE_DIR = 2'b01,
    ATTHP_SEPARATE_RW = 2'b10
  } atthp_access_e;

endpackage : atthp_pkg

// >>> atthp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "atthp_map.svh"

module atthp_host_port #(
  parameter int CTRL_STAGES = `ATTHP_CTRL_STAGES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire atthp_pkg::atthp_host_s hostBus,
  input wire atthp_pkg::atthp_xcvr_s xcvr,
  output logic [3:0] dataOut,
  output logic dataOe,
  output atthp_pkg::atthp_ctrl_s ctrl,
  output logic [3:0] toneCode,
  output logic toneLoad,
  output logic interruptProgressPinOut,
  output logic interruptProgressPinOe
);

  // True while the pins show the write phase of an access.
  function automatic logic writePhase(
    input atthp_pkg::atthp_access_e style,
    input atthp_pkg::atthp_host_s h
  );
    logic r;
    r = 1'b0;
    if (style == atthp_pkg::ATTHP_STROBE_DIR) begin
      r = ~h.csN & h.strobe & ~h.direction;
    end else if (style == atthp_pkg::ATTHP_SEPARATE_RW) begin
      r = ~h.csN & ~h.direction;
    end
    return r;
  endfunction : writePhase

  // True while the pins show the read phase of an access.
  function automatic logic readPhase(
    input atthp_pkg::atthp_access_e style,
    input atthp_pkg::atthp_host_s h
  );
    logic r;
    r = 1'b0;
    if (style == atthp_pkg::ATTHP_STROBE_DIR) begin
      r = ~h.csN & h.strobe & h.direction;
    end else if (style == atthp_pkg::ATTHP_SEPARATE_RW) begin
      r = ~h.csN & ~h.strobe;
    end
    return r;
  endfunction : readPhase

  atthp_pkg::atthp_host_s hostPrev;
  atthp_pkg::atthp_access_e accessState;
  logic accessDone;
  logic regLatch;
  logic csFall;
  logic csRise;
  logic wrCommit;
  logic rdEnd;
  logic rdNow;
  logic [3:0] controlFirst;
  logic [3:0] controlSecond;
  logic secondControlSteer;
  logic [3:0] digitCodeReceive;
  logic txEmpty;
  logic rxFull;
  logic delayedSteer;
  logic [3:0] transceiverState;
  logic cpMode;
  atthp_pkg::atthp_ctrl_s next_ctrl;
  atthp_pkg::atthp_ctrl_s ctrlPipe [CTRL_STAGES];

  // Previous pin sample; edges are found against it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostPrev <= `ATTHP_HOST_IDLE;
    end else begin
      hostPrev <= hostBus;
    end
  end

  assign csFall = hostPrev.csN & ~hostBus.csN;
  assign csRise = ~hostPrev.csN & hostBus.csN;

  // Bus style is chosen from the strobe pin at the select fall.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accessState <= atthp_pkg::ATTHP_IDLE;
    end else begin
      case (accessState)
        atthp_pkg::ATTHP_IDLE: begin
          if (csFall) begin
            if (hostBus.strobe) begin
              accessState <= atthp_pkg::ATTHP_SEPARATE_RW;
            end else begin
              accessState <= atthp_pkg::ATTHP_STROBE_DIR;
            end
          end
        end
        atthp_pkg::ATTHP_STROBE_DIR, atthp_pkg::ATTHP_SEPARATE_RW: begin
          if (csRise) begin
            accessState <= atthp_pkg::ATTHP_IDLE;
          end
        end
        default: begin
          accessState <= atthp_pkg::ATTHP_IDLE;
        end
      endcase
    end
  end

  // A phase ends when its strobe drops or select rises, whichever is first.
  // The done flag stops a second commit if both happen in one access.
  // single access qualifier.
  assign wrCommit = (accessState != atthp_pkg::ATTHP_IDLE) & ~accessDone &
                    writePhase(accessState, hostPrev) & ~writePhase(accessState, hostBus);
  assign rdEnd = (accessState != atthp_pkg::ATTHP_IDLE) & ~accessDone &
                 readPhase(accessState, hostPrev) & ~readPhase(accessState, hostBus);
  assign rdNow = readPhase(accessState, hostBus) & readPhase(accessState, hostPrev);

  // One commit per select cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accessDone <= 1'b0;
    end else if (csFall) begin
      accessDone <= 1'b0;
    end else if (wrCommit | rdEnd) begin
      accessDone <= 1'b1;
    end
  end

  // Every access takes the address at the select fall; strobe/direction buses
  // take it again, stable, when the data strobe rises.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regLatch <= `ATTHP_RS_DATA;
    end else begin
      if (csFall) begin
        regLatch <= hostBus.regSelect;
      end else if (accessState == atthp_pkg::ATTHP_STROBE_DIR &&
                   hostBus.strobe && !hostPrev.strobe) begin
        regLatch <= hostBus.regSelect;
      end
    end
  end

  // Transmit code register; write data is taken from the last phase sample.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      toneCode <= 4'h0;
      toneLoad <= 1'b0;
    end else begin
      toneLoad <= 1'b0;
      if (wrCommit && regLatch == `ATTHP_RS_DATA) begin
        toneCode <= hostPrev.data;
        toneLoad <= 1'b1;
      end
    end
  end

  // Both control registers sit behind one address; the steer flag picks.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      controlFirst <= `ATTHP_CRA_RESET;
      controlSecond <= `ATTHP_CRB_RESET;
      secondControlSteer <= 1'b0;
    end else begin
      if (wrCommit && regLatch == `ATTHP_RS_CONTROL) begin
        if (secondControlSteer) begin
          controlSecond <= hostPrev.data;
          secondControlSteer <= 1'b0;
        end else begin
          controlFirst <= hostPrev.data;
          secondControlSteer <= hostPrev.data[`ATTHP_CRA_STEER];
        end
      end
    end
  end

  assign cpMode = controlFirst[`ATTHP_CRA_MODE];

  // Receive code register follows validated digits, not host strobes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      digitCodeReceive <= 4'h0;
    end else begin
      if (xcvr.digitValid && !cpMode) begin
        digitCodeReceive <= xcvr.digitCode;
      end
    end
  end

  // The transmit and receive flags are set by transceiver events and cleared by a status read, and the burst-off
  // bit holds the transmit flag clear; a set in the cycle of a clearing read wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txEmpty <= 1'b0;
    end else begin
      if (controlSecond[`ATTHP_CRB_BURST_OFF]) begin
        txEmpty <= 1'b0;
      end else if (xcvr.txReady) begin
        txEmpty <= 1'b1;
      end else if (rdEnd && regLatch == `ATTHP_RS_CONTROL) begin
        txEmpty <= 1'b0;
      end
    end
  end

  // Receive full flag.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxFull <= 1'b0;
    end else begin
      if (xcvr.digitValid && !cpMode) begin
        rxFull <= 1'b1;
      end else if (rdEnd && regLatch == `ATTHP_RS_CONTROL) begin
        rxFull <= 1'b0;
      end
    end
  end

  // Delayed steering follows tone absence and presence.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      delayedSteer <= 1'b0;
    end else begin
      if (xcvr.toneAbsent && !cpMode) begin
        delayedSteer <= 1'b1;
      end else if (xcvr.digitValid && !cpMode) begin
        delayedSteer <= 1'b0;
      end
    end
  end

  // Status word is built live at every read.
  always_comb begin
    transceiverState = 4'h0;
    transceiverState[`ATTHP_ST_IRQ] = txEmpty | rxFull;
    transceiverState[`ATTHP_ST_TX_EMPTY] = txEmpty;
    transceiverState[`ATTHP_ST_RX_FULL] = rxFull;
    transceiverState[`ATTHP_ST_DELAYED] = delayedSteer;
  end

  // Read data waits one cycle into the phase so the late address on a
  // strobe/direction bus has settled before the pins are driven.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut <= 4'h0;
      dataOe <= 1'b0;
    end else begin
      dataOe <= rdNow;
      if (regLatch == `ATTHP_RS_CONTROL) begin
        dataOut <= transceiverState;
      end else begin
        dataOut <= digitCodeReceive;
      end
    end
  end

  // Control word as the transceiver sees it.
  always_comb begin
    next_ctrl = `ATTHP_CTRL_IDLE;
    next_ctrl.toneOutputEnable = controlFirst[`ATTHP_CRA_TONE];
    next_ctrl.progressModeSelect = controlFirst[`ATTHP_CRA_MODE];
    next_ctrl.interruptEnable = controlFirst[`ATTHP_CRA_IRQ];
    next_ctrl.receiverDisable = controlSecond[`ATTHP_CRB_RX_OFF];
    if (controlFirst[`ATTHP_CRA_TONE]) begin
      next_ctrl.burstEnable = ~controlSecond[`ATTHP_CRB_BURST_OFF];
      next_ctrl.singleTone = controlSecond[`ATTHP_CRB_SINGLE];
      next_ctrl.columnTone = controlSecond[`ATTHP_CRB_COLUMN];
    end
  end

  // Staging keeps a half-written pair of registers from glitching the
  // transmitter; the cost is a fixed lag on every setting.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CTRL_STAGES; i++) begin
        ctrlPipe[i] <= `ATTHP_CTRL_IDLE;
      end
      ctrl <= `ATTHP_CTRL_IDLE;
    end else begin
      ctrlPipe[0] <= next_ctrl;
      for (int i = 1; i < CTRL_STAGES; i++) begin
        ctrlPipe[i] <= ctrlPipe[i - 1];
      end
      ctrl <= ctrlPipe[CTRL_STAGES - 1];
    end
  end

  // Open-drain pin: only ever pulled low, so the data bit stays zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interruptProgressPinOut <= 1'b0;
      interruptProgressPinOe <= 1'b0;
    end else begin
      interruptProgressPinOut <= 1'b0;
      if (!ctrlPipe[CTRL_STAGES - 1].interruptEnable) begin
        interruptProgressPinOe <= 1'b0;
      end else if (ctrlPipe[CTRL_STAGES - 1].progressModeSelect) begin
        interruptProgressPinOe <= ~xcvr.cpSquare;
      end else begin
        interruptProgressPinOe <= txEmpty | rxFull;
      end
    end
  end

endmodule : atthp_host_port
`default_nettype wire

// >>> atthp_host_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module atthp_host_port_asserts #(
  parameter int CTRL_STAGES = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire atthp_pkg::atthp_host_s hostBus,
  input wire atthp_pkg::atthp_xcvr_s xcvr,
  input wire logic [3:0] dataOut,
  input wire logic dataOe,
  input wire atthp_pkg::atthp_ctrl_s ctrl,
  input wire logic [3:0] toneCode,
  input wire logic toneLoad,
  input wire logic interruptProgressPinOut,
  input wire logic interruptProgressPinOe
);
  localparam int LAG0 = CTRL_STAGES + 1;
  localparam int LAG1 = CTRL_STAGES + 2;
  atthp_pkg::atthp_host_s prev;
  logic sepStyle;
  logic steer;
  logic [3:0] lastWr;
  logic commit;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A write lands when its phase was seen last sample and is gone now.
  assign commit = !prev.csN && !prev.direction && (sepStyle || prev.strobe)
    && !(!hostBus.csN && !hostBus.direction && (sepStyle || hostBus.strobe));
  // Previous pin sample, idle while in reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) prev <= 8'h80;
    else prev <= hostBus;
  end
  // Bus style is taken from the strobe at the select fall.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) sepStyle <= 1'b0;
    else if (prev.csN && !hostBus.csN) sepStyle <= hostBus.strobe;
  end
  // Steering mirror and the last written data word.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      steer <= 1'b0;
      lastWr <= 4'h0;
    end else if (commit) begin
      lastWr <= prev.data;
      if (prev.regSelect) steer <= !steer && prev.data[3];
    end
  end
  property p_pin_open_drain; interruptProgressPinOut == 1'b0; endproperty
  a_pin_open_drain: assert property (p_pin_open_drain)
    else $error("interrupt pin driven high");
  property p_load_pulse; toneLoad |=> !toneLoad; endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("tone load longer than one cycle");
  property p_code_hold; $changed(toneCode) |-> toneLoad; endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("tone code changed without a load");
  property p_tx_load;
    commit && !prev.regSelect |-> ##[1:2] (toneLoad && toneCode == lastWr);
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("data write did not load the tone code");
  property p_oe_select; dataOe |-> !$past(hostBus.csN) || !$past(hostBus.csN, 2); endproperty
  a_oe_select: assert property (p_oe_select)
    else $error("read data driven without chip select");
  property p_tone_gate;
    !ctrl.toneOutputEnable |-> !ctrl.burstEnable && !ctrl.singleTone && !ctrl.columnTone;
  endproperty
  a_tone_gate: assert property (p_tone_gate)
    else $error("transmit setting active with tone output off");
  property p_irq_off; (!ctrl.interruptEnable) [*3] |-> !$past(interruptProgressPinOe); endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt pin pulled with interrupts disabled");
  property p_first_ctrl;
    commit && prev.regSelect && !steer |-> ##[LAG0:LAG1] (ctrl.toneOutputEnable == lastWr[0]
      && ctrl.progressModeSelect == lastWr[1] && ctrl.interruptEnable == lastWr[2]);
  endproperty
  a_first_ctrl: assert property (p_first_ctrl)
    else $error("first control write not applied");
  property p_second_ctrl;
    commit && prev.regSelect && steer |-> ##[LAG0:LAG1] (ctrl.receiverDisable == lastWr[1]
      && ctrl.singleTone == (lastWr[2] && ctrl.toneOutputEnable));
  endproperty
  a_second_ctrl: assert property (p_second_ctrl)
    else $error("steered write did not reach second control");
  // The pin and the visible control word leave the same stage, so they line up.
  property p_progress_pin;
    ctrl.interruptEnable && ctrl.progressModeSelect
      |-> interruptProgressPinOe == !$past(xcvr.cpSquare);
  endproperty
  a_progress_pin: assert property (p_progress_pin)
    else $error("interrupt pin does not follow the progress square wave");
endmodule : atthp_host_port_asserts

bind atthp_host_port atthp_host_port_asserts #(.CTRL_STAGES(CTRL_STAGES)) u_asserts (
  .clk(clk), .sys_rst(sys_rst), .hostBus(hostBus), .xcvr(xcvr), .dataOut(dataOut),
  .dataOe(dataOe), .ctrl(ctrl), .toneCode(toneCode), .toneLoad(toneLoad),
  .interruptProgressPinOut(interruptProgressPinOut),
  .interruptProgressPinOe(interruptProgressPinOe));
`default_nettype wire

// >>> atthp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module atthp_host_model (
  input wire logic clk,
  input wire logic [3:0] dataOut,
  input wire logic dataOe,
  input wire logic interruptProgressPinOe,
  output atthp_pkg::atthp_host_s hostBus,
  output logic pinLevel
);
  logic sepMode;
  // The open-drain pin has a pull-up, so it reads high when nobody sinks it.
  assign pinLevel = !interruptProgressPinOe;
  initial begin
    sepMode = 1'b0;
    hostBus = 8'h80;
  end
  // One access; the style is announced by the strobe level at the select fall.
  task automatic access(input logic rd, input logic rs, input logic [3:0] wd,
                        output logic [4:0] q);
    @(negedge clk);
    hostBus = {1'b0, sepMode, 1'b1, rs, wd};
    repeat (2) @(negedge clk);
    hostBus.strobe = sepMode ? !rd : 1'b1;
    hostBus.direction = rd;
    repeat (4) @(negedge clk);
    q = {dataOe, dataOut};
    hostBus.strobe = sepMode;
    hostBus.direction = 1'b1;
    repeat (2) @(negedge clk);
    hostBus.csN = 1'b1;
    hostBus.data = ~wd;
    repeat (2) @(negedge clk);
  endtask : access
  // Software reset sequence; the third write (fourth access) sets the steer bit.
  task automatic init(output logic [4:0] q);
    for (int i = 0; i < 6; i++) access(i == 0 || i == 5, 1'b1, i == 3 ? 4'h8 : 4'h0, q);
  endtask : init
endmodule : atthp_host_model
`default_nettype wire

// >>> atthp_host_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module atthp_host_port_test;
  logic clk, sys_rst, pin, pinOe, dataOe, steer;
  atthp_pkg::atthp_host_s hostBus;
  atthp_pkg::atthp_xcvr_s xcvr;
  atthp_pkg::atthp_ctrl_s ctrl;
  logic [3:0] dataOut, toneCode, control_first, control_second;
  logic [4:0] q;
  int miscompares, checked, seed, r;
  atthp_host_port u_dut (
    .clk(clk), .sys_rst(sys_rst), .hostBus(hostBus), .xcvr(xcvr), .dataOut(dataOut),
    .dataOe(dataOe), .ctrl(ctrl), .toneCode(toneCode), .toneLoad(),
    .interruptProgressPinOut(), .interruptProgressPinOe(pinOe));
  atthp_host_model u_host (
    .clk(clk), .dataOut(dataOut), .dataOe(dataOe), .interruptProgressPinOe(pinOe),
    .hostBus(hostBus), .pinLevel(pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Expected control outputs; transmit settings vanish while the tone is off.
  function automatic logic [6:0] ctrlExp(input logic [3:0] a, input logic [3:0] b);
    return {a[0], a[1], a[2], !b[0] && a[0], b[1], b[2] && a[0], b[3] && a[0]};
  endfunction : ctrlExp
  function automatic logic [3:0] stat(input logic tx, input logic rx, input logic dly);
    return {dly, rx, tx, tx || rx};
  endfunction : stat
  // Writes keep a mirror of both control registers and the steering state.
  task automatic wr(input logic rs, input logic [3:0] d);
    u_host.access(1'b0, rs, d, q);
    if (rs && steer) control_second = d;
    else if (rs) control_first = d;
    if (rs) steer = !steer && d[3];
    repeat (4) @(negedge clk);
    if (rs) check("control", {1'b0, ctrl}, {1'b0, ctrlExp(control_first, control_second)});
    else check("tone code", {4'h0, toneCode}, {4'h0, d});
  endtask : wr
  task automatic rd(input logic rs, input logic [3:0] e);
    u_host.access(1'b1, rs, 4'h0, q);
    check(rs ? "status" : "receive data", {3'h0, q}, {4'h1, e});
  endtask : rd
  task automatic ev(input int k, input logic [3:0] c);
    @(negedge clk);
    xcvr.digitCode = c;
    {xcvr.digitValid, xcvr.toneAbsent, xcvr.txReady} = 3'b100 >> k;
    @(negedge clk);
    {xcvr.digitValid, xcvr.toneAbsent, xcvr.txReady} = 3'b000;
  endtask : ev
  // A hang ends the run well after the expected nine hundred or so cycles.
  initial begin
    #(8 * 20000);
    miscompares++;
    end_of_test;
  end
  initial begin
    seed = 32'hfa8c;
    miscompares = 0;
    checked = 0;
    xcvr = '0;
    sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    for (int st = 0; st < 2; st++) begin
      u_host.sepMode = st[0];
      u_host.init(q);
      control_first = 4'h0;
      control_second = 4'h0;
      steer = 1'b0;
      for (int i = 0; i < 4; i++) begin
        r = $random(seed);
        wr(1'b0, i == 0 ? 4'hf : r[3:0]);
      end
      // Digit interrupt first masked, then enabled.
      for (int ie = 0; ie < 2; ie++) begin
        r = $random(seed);
        wr(1'b1, {1'b0, ie[0], 2'b01});
        ev(0, r[3:0]);
        repeat (6) @(negedge clk);
        check("pin", {7'h0, pin}, {7'h0, !ie[0]});
        rd(1'b0, r[3:0]);
        rd(1'b1, stat(1'b0, 1'b1, 1'b0));
        check("pin", {7'h0, pin}, 8'h01);
        rd(1'b1, stat(1'b0, 1'b0, 1'b0));
      end
      ev(1, 4'h0);
      rd(1'b1, stat(1'b0, 1'b0, 1'b1));
      ev(0, r[3:0]);
      rd(1'b1, stat(1'b0, 1'b1, 1'b0));
      // Steer into the second register with burst on, then back to the first.
      r = $random(seed);
      wr(1'b1, 4'hd);
      wr(1'b1, r[3:0] & 4'he);
      ev(2, 4'h0);
      repeat (6) @(negedge clk);
      check("pin", {7'h0, pin}, 8'h00);
      rd(1'b1, stat(1'b1, 1'b0, 1'b0));
      wr(1'b1, 4'h5);
      wr(1'b1, 4'hd);
      wr(1'b1, 4'h1);
      ev(2, 4'h0);
      rd(1'b1, stat(1'b0, 1'b0, 1'b0));
      // Progress mode: no digits, square wave copied to the pin.
      wr(1'b1, 4'h6);
      ev(0, 4'h3);
      rd(1'b1, stat(1'b0, 1'b0, 1'b0));
      for (int k = 0; k < 2; k++) begin
        xcvr.cpSquare = !k[0];
        repeat (8) @(negedge clk);
        check("pin", {7'h0, pin}, {7'h0, !k[0]});
      end
      wr(1'b1, 4'h0);
    end
    end_of_test;
  end
endmodule : atthp_host_port_test
`default_nettype wire
